// ---- core/mbst_pkg.sv ----
// mbst_pkg: constants, state codes and pin carriers of the memory boundary-scan tap.
// assumes: used by mbst_tap and the testbench; every use is written mbst_pkg::name.
package mbst_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clocks
   localparam int CLK_PERIOD_NS   = 25;
   localparam int TLR_TMS_EDGES   = 5;

   ////////////////////////////////////////////////////////////////////////////
   // instruction register
   localparam int            IR_W         = 3;
   localparam logic [2:0]    INS_EXTEST   = 3'h0;
   localparam logic [2:0]    INS_IDCODE   = 3'h1;
   localparam logic [2:0]    INS_SAMPLE_Z = 3'h2;
   localparam logic [2:0]    INS_SAMPLE   = 3'h4;
   localparam logic [2:0]    INS_BYPASS   = 3'h7;
   localparam logic [1:0]    IR_CAPTURE   = 2'h1;
   localparam logic          IR_CAP_HI    = 1'h0;

   ////////////////////////////////////////////////////////////////////////////
   // data registers
   localparam logic          BYPASS_CAPTURE = 1'h0;
   localparam int            ID_W           = 32;
   // arbitrary neutral code; bit 0 must be one
   localparam logic [31:0]   ID_DEFAULT     = 32'h0000_0001;
   localparam int            BSR_LEN        = 8;

   ////////////////////////////////////////////////////////////////////////////
   // controller states
   typedef enum logic [3:0] {
      ST_TLR      = 4'hf,
      ST_RTI      = 4'hc,
      ST_SEL_DR   = 4'h7,
      ST_CAP_DR   = 4'h6,
      ST_SHIFT_DR = 4'h2,
      ST_EX1_DR   = 4'h1,
      ST_PAUSE_DR = 4'h3,
      ST_EX2_DR   = 4'h0,
      ST_UPD_DR   = 4'h5,
      ST_SEL_IR   = 4'h4,
      ST_CAP_IR   = 4'he,
      ST_SHIFT_IR = 4'ha,
      ST_EX1_IR   = 4'h9,
      ST_PAUSE_IR = 4'hb,
      ST_EX2_IR   = 4'h8,
      ST_UPD_IR   = 4'hd
   } mbst_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // pin carriers; driven flags model the internal pull-ups
   typedef struct packed {
      logic tms;
      logic tms_driven;
      logic tdi;
      logic tdi_driven;
   } mbst_pins_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } mbst_pins_out_t;

endpackage : mbst_pkg

// ---- core/mbst_tap.sv ----
// mbst_tap: boundary-scan test access port of a synchronous burst memory.
// assumes: tck comes from the scan controller, unrelated to clk; reset is the
// power-up reset on clk; the pad level of tdo is resolved outside from tdo_oe.
//
// Notes on behaviour
// - state sequencing and register selection follow the 1990 boundary-scan standard
// - tms and tdi are captured on the rising test clock edge
// - serial output changes on the falling test clock edge, and is forced low on clk while a power-up reset is pending
// - sampled mode select alone steers the controller transitions
// - an undriven mode select acts as logic one
// - an undriven serial data input acts as logic one
// - serial path chosen from controller state and loaded instruction
// - serial output driven only in shifting states, inactive otherwise
// - no asynchronous test reset; only state sequence or power-up resets
// - five rising edges with mode select high reach test-logic-reset
// - port reset at power-up and inactive, memory unaffected, until clocked
// - instruction register is three bits wide
// - power-up and test-logic-reset load the identification instruction
// - instruction capture loads binary 01 into the two lowest bits
// - bypass path is one shift bit between data in and data out
module mbst_tap #(
   parameter int            BSR_LEN = mbst_pkg::BSR_LEN,
   parameter logic [31:0]   ID_CODE = mbst_pkg::ID_DEFAULT
) (
   // system clock and power-up reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // link clock from the scan controller
   input  wire logic                   tck,
   // scan pins
   input  wire mbst_pkg::mbst_pins_in_t pins_i,
   output mbst_pkg::mbst_pins_out_t    pins_o,
   // memory pad ring, clk domain
   input  wire logic [BSR_LEN-1:0]     pad_levels,
   output logic      [BSR_LEN-1:0]     pad_drive,
   output logic                        pad_drive_en,
   output logic                        pad_force_hiz,
   // memory side, clk domain
   output logic                        tap_quiet
);

   ////////////////////////////////////////////////////////////////////////////
   // power-up request held in clk domain until the tck side has seen it
   logic por_pend_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic tlr_s1_q;
   logic tlr_s2_q;
   logic rst_s1_q;
   logic rst_tck_q;
   logic st_tlr_q;

   // a short reset pulse could slip between slow tck edges, so it is stretched
   always_ff @(posedge clk) begin
      if (reset) begin
         por_pend_q <= 1'b1;
      end else if (ack_s2_q) begin
         por_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         tlr_s1_q <= 1'b1;
         tlr_s2_q <= 1'b1;
      end else begin
         ack_s1_q <= rst_tck_q;
         ack_s2_q <= ack_s1_q;
         tlr_s1_q <= st_tlr_q;
         tlr_s2_q <= tlr_s1_q;
      end
   end

   // memory logic sees no test influence while pending or in test-logic-reset
   assign tap_quiet = por_pend_q | tlr_s2_q;

   // tck side: no test reset pin, only the stretched power-up level
   always_ff @(posedge tck) begin
      rst_s1_q  <= por_pend_q;
      rst_tck_q <= rst_s1_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling; the controller launches on its own clock, so one stage only
   logic tms_eff;
   logic tdi_eff;

   assign tms_eff = pins_i.tms_driven ? pins_i.tms : 1'b1;
   assign tdi_eff = pins_i.tdi_driven ? pins_i.tdi : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // controller
   mbst_pkg::mbst_state_t st_q;
   mbst_pkg::mbst_state_t st_d;

   function automatic mbst_pkg::mbst_state_t next_state(input mbst_pkg::mbst_state_t s, input logic m);
      case (s)
         mbst_pkg::ST_TLR:      next_state = m ? mbst_pkg::ST_TLR      : mbst_pkg::ST_RTI;
         mbst_pkg::ST_RTI:      next_state = m ? mbst_pkg::ST_SEL_DR   : mbst_pkg::ST_RTI;
         mbst_pkg::ST_SEL_DR:   next_state = m ? mbst_pkg::ST_SEL_IR   : mbst_pkg::ST_CAP_DR;
         mbst_pkg::ST_CAP_DR:   next_state = m ? mbst_pkg::ST_EX1_DR   : mbst_pkg::ST_SHIFT_DR;
         mbst_pkg::ST_SHIFT_DR: next_state = m ? mbst_pkg::ST_EX1_DR   : mbst_pkg::ST_SHIFT_DR;
         mbst_pkg::ST_EX1_DR:   next_state = m ? mbst_pkg::ST_UPD_DR   : mbst_pkg::ST_PAUSE_DR;
         mbst_pkg::ST_PAUSE_DR: next_state = m ? mbst_pkg::ST_EX2_DR   : mbst_pkg::ST_PAUSE_DR;
         mbst_pkg::ST_EX2_DR:   next_state = m ? mbst_pkg::ST_UPD_DR   : mbst_pkg::ST_SHIFT_DR;
         mbst_pkg::ST_UPD_DR:   next_state = m ? mbst_pkg::ST_SEL_DR   : mbst_pkg::ST_RTI;
         mbst_pkg::ST_SEL_IR:   next_state = m ? mbst_pkg::ST_TLR      : mbst_pkg::ST_CAP_IR;
         mbst_pkg::ST_CAP_IR:   next_state = m ? mbst_pkg::ST_EX1_IR   : mbst_pkg::ST_SHIFT_IR;
         mbst_pkg::ST_SHIFT_IR: next_state = m ? mbst_pkg::ST_EX1_IR   : mbst_pkg::ST_SHIFT_IR;
         mbst_pkg::ST_EX1_IR:   next_state = m ? mbst_pkg::ST_UPD_IR   : mbst_pkg::ST_PAUSE_IR;
         mbst_pkg::ST_PAUSE_IR: next_state = m ? mbst_pkg::ST_EX2_IR   : mbst_pkg::ST_PAUSE_IR;
         mbst_pkg::ST_EX2_IR:   next_state = m ? mbst_pkg::ST_UPD_IR   : mbst_pkg::ST_SHIFT_IR;
         mbst_pkg::ST_UPD_IR:   next_state = m ? mbst_pkg::ST_SEL_DR   : mbst_pkg::ST_RTI;
         default:               next_state = mbst_pkg::ST_TLR;
      endcase
   endfunction : next_state

   assign st_d = next_state(st_q, tms_eff);

   always_ff @(posedge tck) begin
      if (rst_tck_q) begin
         st_q     <= mbst_pkg::ST_TLR;
         st_tlr_q <= 1'b1;
      end else begin
         st_q     <= st_d;
         st_tlr_q <= (st_d == mbst_pkg::ST_TLR);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state decode
   wire in_tlr      = (st_q == mbst_pkg::ST_TLR);
   wire in_cap_ir   = (st_q == mbst_pkg::ST_CAP_IR);
   wire in_shift_ir = (st_q == mbst_pkg::ST_SHIFT_IR);
   wire in_upd_ir   = (st_q == mbst_pkg::ST_UPD_IR);
   wire in_cap_dr   = (st_q == mbst_pkg::ST_CAP_DR);
   wire in_shift_dr = (st_q == mbst_pkg::ST_SHIFT_DR);
   wire in_upd_dr   = (st_q == mbst_pkg::ST_UPD_DR);
   wire shifting    = in_shift_ir | in_shift_dr;

   ////////////////////////////////////////////////////////////////////////////
   // instruction register
   logic [mbst_pkg::IR_W-1:0] ir_sr_q;
   logic [mbst_pkg::IR_W-1:0] ir_q;

   always_ff @(posedge tck) begin
      if (rst_tck_q || in_tlr) begin
         ir_q <= mbst_pkg::INS_IDCODE;
      end else if (in_upd_ir) begin
         ir_q <= ir_sr_q;
      end
   end

   always_ff @(posedge tck) begin
      if (in_cap_ir) begin
         ir_sr_q <= {mbst_pkg::IR_CAP_HI, mbst_pkg::IR_CAPTURE};
      end else if (in_shift_ir) begin
         ir_sr_q <= {tdi_eff, ir_sr_q[mbst_pkg::IR_W-1:1]};
      end
   end

   // unknown codes fall back to bypass, as the standard asks
   wire sel_id     = (ir_q == mbst_pkg::INS_IDCODE);
   wire sel_extest = (ir_q == mbst_pkg::INS_EXTEST);
   wire sel_bsr    = sel_extest | (ir_q == mbst_pkg::INS_SAMPLE) | (ir_q == mbst_pkg::INS_SAMPLE_Z);
   wire sel_byp    = !sel_id && !sel_bsr;

   ////////////////////////////////////////////////////////////////////////////
   // data registers
   logic                     bypass_q;
   logic [mbst_pkg::ID_W-1:0] id_sr_q;
   logic [BSR_LEN-1:0]       bsr_sr_q;
   logic [BSR_LEN-1:0]       pad_s1_q;
   logic [BSR_LEN-1:0]       pad_s2_q;
   logic [BSR_LEN-1:0]       bsr_upd_q;

   always_ff @(posedge tck) begin
      if (in_cap_dr) begin
         bypass_q <= mbst_pkg::BYPASS_CAPTURE;
      end else if (in_shift_dr && sel_byp) begin
         bypass_q <= tdi_eff;
      end
   end

   always_ff @(posedge tck) begin
      if (in_cap_dr && sel_id) begin
         id_sr_q <= ID_CODE;
      end else if (in_shift_dr && sel_id) begin
         id_sr_q <= {tdi_eff, id_sr_q[mbst_pkg::ID_W-1:1]};
      end
   end

   // pad ring runs on the memory clock, so its levels are resynchronised here
   always_ff @(posedge tck) begin
      pad_s1_q <= pad_levels;
      pad_s2_q <= pad_s1_q;
   end

   always_ff @(posedge tck) begin
      if (in_cap_dr && sel_bsr) begin
         bsr_sr_q <= pad_s2_q;
      end else if (in_shift_dr && sel_bsr) begin
         bsr_sr_q <= {tdi_eff, bsr_sr_q[BSR_LEN-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (in_upd_dr && sel_bsr) begin
         bsr_upd_q <= bsr_sr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output; a full half period of hold toward the next device
   wire ser_bit = in_shift_ir ? ir_sr_q[0]  :
                  sel_id      ? id_sr_q[0]  :
                  sel_bsr     ? bsr_sr_q[0] : bypass_q;

   logic tdo_q;
   logic tdo_oe_q;

   always_ff @(negedge tck) begin
      if (rst_tck_q) begin
         tdo_oe_q <= 1'b0;
         tdo_q    <= 1'b0;
      end else begin
         tdo_oe_q <= shifting;
         tdo_q    <= shifting ? ser_bit : 1'b0;
      end
   end

   // rising-edge copy of tdo, so a change launched on the wrong edge shows up
   logic tdo_rise_q;

   always_ff @(posedge tck) begin
      tdo_rise_q <= tdo_q;
   end

   // gated by the clk-side flag so the pin stays quiet before tck ever runs
   assign pins_o.tdo_oe = tdo_oe_q & ~por_pend_q;
   assign pins_o.tdo    = tdo_q & ~por_pend_q;

   ////////////////////////////////////////////////////////////////////////////
   // pad ring control; quiet memory sees none of it
   assign pad_drive     = bsr_upd_q & {BSR_LEN{~tap_quiet}};
   assign pad_drive_en  = sel_extest & ~tap_quiet;
   assign pad_force_hiz = (ir_q == mbst_pkg::INS_SAMPLE_Z) & ~tap_quiet;

   ////////////////////////////////////////////////////////////////////////////
   // checks, tck domain
   property p_five_tms;
      @(posedge tck) disable iff (rst_tck_q)
      tms_eff [*5] |=> (st_q == mbst_pkg::ST_TLR);
   endproperty
   a_five_tms: assert property (p_five_tms) else $error("five high tms did not reach reset");

   property p_ir_default;
      @(posedge tck) disable iff (rst_tck_q)
      (st_q == mbst_pkg::ST_TLR) |=> (ir_q == mbst_pkg::INS_IDCODE);
   endproperty
   a_ir_default: assert property (p_ir_default) else $error("instruction not idcode after reset");

   property p_cap_ir;
      @(posedge tck) disable iff (rst_tck_q)
      in_cap_ir |=> (ir_sr_q[1:0] == 2'h1);
   endproperty
   a_cap_ir: assert property (p_cap_ir) else $error("capture-ir did not load 01");

   property p_upd_ir;
      @(posedge tck) disable iff (rst_tck_q)
      in_upd_ir |=> (ir_q == $past(ir_sr_q));
   endproperty
   a_upd_ir: assert property (p_upd_ir) else $error("update-ir did not load instruction");

   property p_bypass;
      @(posedge tck) disable iff (rst_tck_q)
      (in_shift_dr && sel_byp) |=> (bypass_q == $past(tdi_eff));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass bit did not take tdi");

   property p_oe_states;
      @(posedge tck) disable iff (rst_tck_q || por_pend_q)
      pins_o.tdo_oe == shifting;
   endproperty
   a_oe_states: assert property (p_oe_states) else $error("tdo enable outside shift states");

   property p_tdo_path;
      @(posedge tck) disable iff (rst_tck_q || por_pend_q)
      (in_shift_dr && sel_id) |-> (pins_o.tdo == id_sr_q[0]);
   endproperty
   a_tdo_path: assert property (p_tdo_path) else $error("tdo not fed from id register");

   property p_tdo_stable;
      @(negedge tck) disable iff (rst_tck_q || por_pend_q)
      tdo_q == tdo_rise_q;
   endproperty
   a_tdo_stable: assert property (p_tdo_stable) else $error("tdo moved on a rising edge");

   property p_idle_hold;
      @(posedge tck) disable iff (rst_tck_q)
      (st_q == mbst_pkg::ST_RTI && !tms_eff) |=> (st_q == mbst_pkg::ST_RTI);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle left with tms low");

   property p_exit_shift;
      @(posedge tck) disable iff (rst_tck_q)
      (in_shift_dr && tms_eff) |=> (st_q == mbst_pkg::ST_EX1_DR);
   endproperty
   a_exit_shift: assert property (p_exit_shift) else $error("shift-dr did not exit on tms");

   property p_float_tms;
      @(posedge tck) disable iff (rst_tck_q)
      (!pins_i.tms_driven && in_tlr) |=> in_tlr;
   endproperty
   a_float_tms: assert property (p_float_tms) else $error("floating tms left reset");

   property p_tdo_idle;
      @(posedge tck) disable iff (rst_tck_q || por_pend_q)
      !shifting |-> !pins_o.tdo;
   endproperty
   a_tdo_idle: assert property (p_tdo_idle) else $error("tdo high outside shift states");

   property p_ir_path;
      @(posedge tck) disable iff (rst_tck_q || por_pend_q)
      in_shift_ir |-> (pins_o.tdo == ir_sr_q[0]);
   endproperty
   a_ir_path: assert property (p_ir_path) else $error("tdo not fed from instruction register");

   property p_byp_path;
      @(posedge tck) disable iff (rst_tck_q || por_pend_q)
      (in_shift_dr && sel_byp) |-> (pins_o.tdo == bypass_q);
   endproperty
   a_byp_path: assert property (p_byp_path) else $error("tdo not fed from bypass bit");

   property p_sel_ir_exit;
      @(posedge tck) disable iff (rst_tck_q)
      (st_q == mbst_pkg::ST_SEL_IR && tms_eff) |=> in_tlr;
   endproperty
   a_sel_ir_exit: assert property (p_sel_ir_exit) else $error("select-ir did not go to reset");

   property p_id_capture;
      @(posedge tck) disable iff (rst_tck_q)
      (in_cap_dr && sel_id) |=> (id_sr_q == ID_CODE);
   endproperty
   a_id_capture: assert property (p_id_capture) else $error("capture-dr did not load id code");

endmodule : mbst_tap

// ---- testbench/mbst_scan_ctl.sv ----
// mbst_scan_ctl: behavioural board scan controller facing the tap pins.
// assumes: the bench calls one task at a time; tck stands low between frames.
module mbst_scan_ctl (
   // scan link
   output logic                         tck,
   output mbst_pkg::mbst_pins_in_t      pins_i,
   input  wire mbst_pkg::mbst_pins_out_t pins_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic float_tms;
   logic float_tdi;

   initial begin
      tck       = 1'h0;
      pins_i    = 4'h5;
      float_tms = 1'h0;
      float_tdi = 1'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one tck period: inputs move while low, tdo taken just before the rise
   task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
      // a released line toggles, so only the driven flag may make it read as one
      pins_i.tms_driven = ~float_tms;
      pins_i.tms        = float_tms ? ~pins_i.tms : tms;
      pins_i.tdi_driven = ~float_tdi;
      pins_i.tdi        = float_tdi ? ~pins_i.tdi : tdi;
      #62.5;
      tdo = pins_o.tdo;
      oe  = pins_o.tdo_oe;
      tck = 1'h1;
      #62.5;
      tck = 1'h0;
   endtask : tick

   task automatic walk(input logic tms, input int cnt);
      logic d;
      logic e;
      repeat (cnt) tick(tms, 1'h0, d, e);
   endtask : walk

   // header from run-test/idle, n shift bits lsb first, then update and idle
   task automatic frame(input logic [7:0] hdr, input int nh, input logic [31:0] tdi, input int n,
                        output logic [31:0] tdo, output int n_oe);
      logic d;
      logic e;
      tdo  = '0;
      n_oe = 0;
      for (int i = 0; i < nh + n + 2; i++) begin
         if (i < nh) tick(hdr[i], 1'h0, d, e);
         else if (i < nh + n) begin
            tick(i == nh + n - 1, tdi[i-nh], d, e);
            tdo[i-nh] = d;
         end
         else tick(i == nh + n, 1'h0, d, e);
         n_oe += int'(e);
      end
   endtask : frame

endmodule : mbst_scan_ctl

// ---- testbench/tb_top.sv ----
// tb_top: self-checking bench for mbst_tap with a scan controller model.
// assumes: default BSR_LEN and ID_CODE; pad levels held steady during capture.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                     clk;
   logic                     reset;
   logic                     tck;
   mbst_pkg::mbst_pins_in_t  pins_i;
   mbst_pkg::mbst_pins_out_t pins_o;
   logic [7:0]               pad_levels;
   logic [7:0]               pad_drive;
   logic                     pad_drive_en;
   logic                     pad_force_hiz;
   logic                     tap_quiet;
   int                       fails;
   int                       n_compared;
   logic [31:0]              got;
   int                       noe;

   typedef struct {
      logic [2:0]  ins;
      int          n;
      logic [31:0] tdi;
      logic [31:0] exp;
      logic        en;
      logic        hiz;
   } mbst_row_t;

   mbst_row_t rows [8] = '{
      '{3'h1, 32, 32'h0, mbst_pkg::ID_DEFAULT, 1'h0, 1'h0},
      '{3'h7, 8, 32'h96, 32'h2c, 1'h0, 1'h0},
      '{3'h3, 8, 32'h96, 32'h2c, 1'h0, 1'h0},
      '{3'h5, 8, 32'h96, 32'h2c, 1'h0, 1'h0},
      '{3'h6, 8, 32'h96, 32'h2c, 1'h0, 1'h0},
      '{3'h4, 8, 32'h0, 32'ha5, 1'h0, 1'h0},
      '{3'h0, 8, 32'h0, 32'ha5, 1'h1, 1'h0},
      '{3'h2, 8, 32'h0, 32'ha5, 1'h0, 1'h1}
   };

   mbst_tap u_dut (
      .clk           (clk),
      .reset         (reset),
      .tck           (tck),
      .pins_i        (pins_i),
      .pins_o        (pins_o),
      .pad_levels    (pad_levels),
      .pad_drive     (pad_drive),
      .pad_drive_en  (pad_drive_en),
      .pad_force_hiz (pad_force_hiz),
      .tap_quiet     (tap_quiet)
   );

   mbst_scan_ctl u_ctl (
      .tck    (tck),
      .pins_i (pins_i),
      .pins_o (pins_o)
   );

   initial clk = 1'h0;
   always #12.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // checks and closing
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   function automatic logic [31:0] msk(input int n);
      msk = (n >= 32) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
   endfunction : msk

   // ir shift checks the capture pattern and that tdo drives only while shifting
   task automatic ir_load(input logic [2:0] ins);
      u_ctl.frame(8'h03, 4, {29'h0, ins}, 3, got, noe);
      chk(got & 32'h7, 32'h1);
      chk(noe, 3);
   endtask : ir_load

   task automatic dr_read(input int n, input logic [31:0] tdi, input logic [31:0] exp);
      u_ctl.frame(8'h01, 3, tdi, n, got, noe);
      chk(got & msk(n), exp);
      chk(noe, n);
   endtask : dr_read

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      fails      = 0;
      n_compared = 0;
      reset      = 1'h1;
      pad_levels = 8'ha5;
      repeat (4) @(posedge clk);
      chk(tap_quiet, 1'h1);
      chk(pins_o.tdo_oe, 1'h0);
      reset <= 1'h0;
      // skew keeps the link clock edges off the system clock edges
      #7.3;
      u_ctl.walk(1'h1, 6);
      u_ctl.walk(1'h0, 1);
      for (int i = 0; i < 8; i++) begin
         ir_load(rows[i].ins);
         chk(pad_drive_en, rows[i].en);
         chk(pad_force_hiz, rows[i].hiz);
         dr_read(rows[i].n, rows[i].tdi, rows[i].exp);
         $display("row %0d done", i);
      end
      // preload a pattern, then extest drives it until the port goes quiet
      ir_load(mbst_pkg::INS_SAMPLE);
      dr_read(8, 32'h3c, 32'ha5);
      chk(pad_drive, 8'h3c);
      ir_load(mbst_pkg::INS_EXTEST);
      chk(pad_drive_en, 1'h1);
      chk(pad_drive, 8'h3c);
      $display("preload and extest done");
      // floating tdi reads as ones through the bypass bit
      ir_load(3'h7);
      u_ctl.float_tdi = 1'h1;
      dr_read(8, 32'h0, 32'hfe);
      u_ctl.float_tdi = 1'h0;
      $display("floating data in done");
      // floating tms for five edges resets and reloads the id instruction
      u_ctl.float_tms = 1'h1;
      u_ctl.walk(1'h0, 5);
      u_ctl.float_tms = 1'h0;
      repeat (4) @(posedge clk);
      chk(tap_quiet, 1'h1);
      chk(pad_drive, 8'h00);
      #7.3;
      u_ctl.walk(1'h0, 1);
      repeat (4) @(posedge clk);
      chk(tap_quiet, 1'h0);
      #7.3;
      dr_read(32, 32'h0, mbst_pkg::ID_DEFAULT);
      $display("floating mode select done");
      // second power-up reset in mid-run, then leave reset with tms low
      ir_load(3'h7);
      @(posedge clk);
      reset <= 1'h1;
      repeat (4) @(posedge clk);
      chk(tap_quiet, 1'h1);
      reset <= 1'h0;
      #7.3;
      u_ctl.walk(1'h0, 6);
      dr_read(32, 32'h0, mbst_pkg::ID_DEFAULT);
      $display("power-up reset done");
      report_and_stop();
   end

   // whole run is a few hundred tck periods; this leaves ample margin
   initial begin
      #300us;
      fails++;
      report_and_stop();
   end

endmodule : tb_top
